//--- inc/omsp_pkg.sv
// shared constants of the open mode serial port: frame layout, register map, link timing
// assumes a single 10 MHz system clock that also serves as the reference for the link divider
package omsp_pkg;
  // system clock
  localparam int CLK_HZ = 10_000_000;
  // frame layout, counted in rising serial clock edges
  localparam int FRAME_BITS = 32;
  localparam int DATA_BITS = 24;
  localparam int REG_ADDR_BITS = 5;
  localparam int CHIP_ADDR_BITS = 3;
  localparam logic [5:0] FRAME_LEN = 6'h20;
  localparam logic [5:0] FRAME_OVER = 6'h21;
  localparam logic [2:0] OWN_CHIP_ADDR = 3'h0;
  // register map
  localparam logic [4:0] ADDR_READ_SELECT = 5'h00;
  localparam logic [4:0] ADDR_VCO_PACKET = 5'h05;
  localparam logic [4:0] ADDR_LINK_RATE = 5'h0a;
  localparam int REG_COUNT = 32;
  localparam int READ_ADDR_LSB = 0;
  localparam int READ_ADDR_MSB = 4;
  localparam int SOFT_RESET_BIT = 5;
  localparam logic [23:0] LINK_RATE_RESET = 24'h002000;
  localparam int RATE_SEL_LSB = 13;
  localparam int RATE_SEL_MSB = 14;
  // forwarded packet layout
  localparam int PACKET_BITS = 16;
  localparam int SUB_ID_MSB = 2;
  localparam int SUB_ADDR_LSB = 3;
  localparam int SUB_ADDR_MSB = 6;
  localparam int SUB_DATA_LSB = 7;
  localparam logic [4:0] PACKET_LAST = 5'h0f;
  // identification value returned from register zero; arbitrary value
  localparam logic [23:0] CHIP_ID = 24'h5a0001;
  // highest allowed link clock
  localparam int LINK_MAX_HZ = 50_000_000;
  localparam int LINK_MIN_HALF = (CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);

  typedef enum logic [0:0] {
    LNK_IDLE = 1'b0,
    LNK_SHIFT = 1'b1
  } omsp_lnk_state_t;

  // reference divided by 2, 4, 8 or 16; half of that period in system clocks
  function automatic logic [3:0] half_period(input logic [1:0] sel);
    logic [3:0] h;
    h = 4'h1 << sel;
    if (int'(h) < LINK_MIN_HALF) begin
      h = 4'(LINK_MIN_HALF);
    end
    return h;
  endfunction
endpackage

//--- inc/omsp_link_if.sv
// request path between the serial port and the internal vco link sender
// both ends run on the same system clock
`timescale 1ns/100ps
interface omsp_link_if;
  logic start;
  logic [15:0] packet;
  logic [1:0] rate_sel;
  logic busy;
  modport port (output start, output packet, output rate_sel, input busy);
  modport sender (input start, input packet, input rate_sel, output busy);
endinterface

//--- verilog/omsp_vco_link.sv
// sender of 16-bit packets on the internal vco link, msb first
// link clock is derived from the system clock, idle low, data changes on its falling edge
`timescale 1ns/100ps
module omsp_vco_link (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // request side
  omsp_link_if.sender req,
  // link pins
  output logic link_clk,
  output logic link_data,
  output logic link_frame
);
  omsp_pkg::omsp_lnk_state_t state_ff;
  logic [15:0] shift_ff;
  logic [4:0] bit_ff;
  logic [3:0] div_ff;
  logic [3:0] half_ff;
  logic clk_ff;
  logic half_done;

  assign half_done = (div_ff == half_ff - 4'h1);
  assign req.busy = (state_ff == omsp_pkg::LNK_SHIFT);
  assign link_clk = clk_ff;
  assign link_data = shift_ff[omsp_pkg::PACKET_BITS-1];
  assign link_frame = (state_ff == omsp_pkg::LNK_SHIFT);

  // a new packet restarts the link so that the last write always reaches the subsystem
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= omsp_pkg::LNK_IDLE;
      shift_ff <= 16'h0000;
      bit_ff <= 5'h00;
      div_ff <= 4'h0;
      half_ff <= 4'h1;
      clk_ff <= 1'b0;
    end else if (clk_en) begin
      if (req.start) begin
        state_ff <= omsp_pkg::LNK_SHIFT;
        shift_ff <= req.packet;
        bit_ff <= 5'h00;
        div_ff <= 4'h0;
        half_ff <= omsp_pkg::half_period(req.rate_sel);
        clk_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          omsp_pkg::LNK_IDLE: begin
            clk_ff <= 1'b0;
          end
          omsp_pkg::LNK_SHIFT: begin
            div_ff <= half_done ? 4'h0 : div_ff + 4'h1;
            if (half_done) begin
              clk_ff <= ~clk_ff;
              if (clk_ff) begin
                if (bit_ff == omsp_pkg::PACKET_LAST) begin
                  state_ff <= omsp_pkg::LNK_IDLE;
                end else begin
                  bit_ff <= bit_ff + 5'h01;
                  shift_ff <= {shift_ff[14:0], 1'b0};
                end
              end
            end
          end
        endcase
      end
    end
  end
endmodule

//--- verilog/omsp_serial_port.sv
// open mode shift-and-strobe serial slave with register file and vco link forwarding
// serial pins are taken as synchronous to clock; the serial clock must stay well below it
//
// Overview of operation
// - frames carry a three-bit chip address so eight devices share the bus
// - device samples data on the first 24 rising serial clock edges
// - five register address bits follow, msb first, on edges 25 to 29
// - three chip address bits come last, msb first, on edges 30 to 32
// - the device answers to chip address 000
// - rising frame strobe commits data to the addressed register
// - each frame shifts out the register named by the stored read address
// - during a frame the shared pin carries serial data instead of lock
// - frame strobe after the 32nd edge returns the shared pin to lock
// - every register 05h write is forwarded msb first over the internal link
// - link rate comes from register 0Ah bits 14:13, default one, reference over four
// - packet bits 2:0 hold the subsystem identifier
// - packet bits 6:3 hold the subsystem register address
// - packet bits 15:7 hold the subsystem data value
// - a rising serial clock first after reset locks in this protocol
// - register zero write stores read address bits 4:0; bit 5 soft resets
`timescale 1ns/100ps
module omsp_serial_port (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial pins
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_strobe,
  output logic shared_lock_serial_out,
  // lock input from the loop
  input wire logic lock_indication,
  // internal vco link
  output logic link_clk,
  output logic link_data,
  output logic link_frame,
  // status
  output logic open_mode_active,
  output logic legacy_single_slave_protocol,
  output logic link_busy
);
  localparam int PW = omsp_pkg::PACKET_BITS;
  localparam int DW = omsp_pkg::DATA_BITS;

  omsp_link_if lnk ();

  logic sclk_d_ff;
  logic strobe_d_ff;
  logic mode_fixed_ff;
  logic open_mode_ff;
  logic [5:0] cnt_ff;
  logic [31:0] shift_ff;
  logic [4:0] read_addr_ff;
  logic [23:0] out_shift_ff;
  logic out_active_ff;
  logic out_ff;
  logic [PW-1:0] packet_ff;
  logic start_ff;
  logic [23:0] regs_ff [omsp_pkg::REG_COUNT];

  logic sclk_rise;
  logic strobe_rise;
  logic commit;
  logic soft_reset;
  logic [23:0] wr_data;
  logic [4:0] wr_addr;
  logic [2:0] wr_chip;
  logic [23:0] rd_word;

  function automatic logic [23:0] reg_read(input logic [4:0] a, input logic [PW-1:0] pkt,
                                           input logic [23:0] stored);
    if (a == omsp_pkg::ADDR_READ_SELECT) begin
      return omsp_pkg::CHIP_ID;
    end else if (a == omsp_pkg::ADDR_VCO_PACKET) begin
      return {{(DW-PW){1'b0}}, pkt};
    end
    return stored;
  endfunction

  assign sclk_rise = sclk & ~sclk_d_ff;
  assign strobe_rise = frame_strobe & ~strobe_d_ff;
  // data, register address and chip address in shift order
  assign wr_data = shift_ff[31:8];
  assign wr_addr = shift_ff[7:3];
  assign wr_chip = shift_ff[2:0];
  // commit only a complete frame for this chip
  assign commit = open_mode_ff && strobe_rise && (cnt_ff == omsp_pkg::FRAME_LEN)
                  && (wr_chip == omsp_pkg::OWN_CHIP_ADDR);
  assign soft_reset = commit && (wr_addr == omsp_pkg::ADDR_READ_SELECT)
                      && wr_data[omsp_pkg::SOFT_RESET_BIT];
  assign rd_word = reg_read(read_addr_ff, packet_ff, regs_ff[read_addr_ff]);

  assign shared_lock_serial_out = out_ff;
  assign open_mode_active = open_mode_ff;
  assign legacy_single_slave_protocol = mode_fixed_ff & ~open_mode_ff;
  assign link_busy = lnk.busy;
  assign lnk.start = start_ff;
  assign lnk.packet = packet_ff;
  assign lnk.rate_sel = regs_ff[omsp_pkg::ADDR_LINK_RATE]
                        [omsp_pkg::RATE_SEL_MSB:omsp_pkg::RATE_SEL_LSB];

  // edge detectors
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b0;
      strobe_d_ff <= 1'b0;
    end else if (clk_en) begin
      sclk_d_ff <= sclk;
      strobe_d_ff <= frame_strobe;
    end
  end

  // protocol choice is made once; only a hard reset reopens it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_fixed_ff <= 1'b0;
      open_mode_ff <= 1'b0;
    end else if (clk_en && !mode_fixed_ff && (sclk_rise || strobe_rise)) begin
      mode_fixed_ff <= 1'b1;
      open_mode_ff <= sclk_rise;
    end
  end

  // frame shifter; extra edges beyond 32 make the frame unusable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 6'h00;
      shift_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (strobe_rise || soft_reset) begin
        cnt_ff <= 6'h00;
      end else if ((open_mode_ff || !mode_fixed_ff) && sclk_rise) begin
        shift_ff <= {shift_ff[30:0], sdi};
        if (cnt_ff != omsp_pkg::FRAME_OVER) begin
          cnt_ff <= cnt_ff + 6'h01;
        end
      end
    end
  end

  // read address and soft reset from register zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_addr_ff <= 5'h00;
    end else if (clk_en && commit && wr_addr == omsp_pkg::ADDR_READ_SELECT) begin
      read_addr_ff <= soft_reset ? 5'h00
                      : wr_data[omsp_pkg::READ_ADDR_MSB:omsp_pkg::READ_ADDR_LSB];
    end
  end

  // register file; register zero and the packet register are held elsewhere
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < omsp_pkg::REG_COUNT; i++) begin
        regs_ff[i] <= 24'h000000;
      end
      regs_ff[omsp_pkg::ADDR_LINK_RATE] <= omsp_pkg::LINK_RATE_RESET;
    end else if (clk_en && commit && wr_addr != omsp_pkg::ADDR_READ_SELECT
                 && wr_addr != omsp_pkg::ADDR_VCO_PACKET) begin
      regs_ff[wr_addr] <= wr_data;
    end
  end

  // packet register; it keeps the last packet sent so software can read it back
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      packet_ff <= 16'h0000;
      start_ff <= 1'b0;
    end else if (clk_en) begin
      start_ff <= commit && (wr_addr == omsp_pkg::ADDR_VCO_PACKET);
      if (commit && wr_addr == omsp_pkg::ADDR_VCO_PACKET) begin
        // identifier, subsystem address and data keep their bit positions
        packet_ff <= wr_data[PW-1:0];
      end
    end
  end

  // read-back shifter: the first rising edge of a frame loads the word and drives its msb
  // the very first rise after reset also picks this protocol, so it must load as well
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_shift_ff <= 24'h000000;
      out_active_ff <= 1'b0;
    end else if (clk_en) begin
      if (strobe_rise || soft_reset) begin
        out_active_ff <= 1'b0;
      end else if ((open_mode_ff || !mode_fixed_ff) && sclk_rise) begin
        out_active_ff <= 1'b1;
        if (cnt_ff == 6'h00) begin
          out_shift_ff <= rd_word;
        end else begin
          out_shift_ff <= {out_shift_ff[22:0], 1'b0};
        end
      end
    end
  end

  // registered pin: lock when idle, read data while a frame runs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_ff <= 1'b0;
    end else if (clk_en) begin
      out_ff <= out_active_ff ? out_shift_ff[DW-1] : lock_indication;
    end
  end

  omsp_vco_link u_link (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req(lnk.sender),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_frame(link_frame)
  );
endmodule

//--- tb/omsp_serial_port_props.sv
// checker of the open mode serial port, watching only its top-level pins
// assumes sclk and the frame strobe are slow, synchronous levels against clock
`timescale 1ns/100ps
module omsp_serial_port_props (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial pins
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_strobe,
  input wire logic shared_lock_serial_out,
  input wire logic lock_indication,
  // link and status
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_frame,
  input wire logic open_mode_active,
  input wire logic legacy_single_slave_protocol,
  input wire logic link_busy
);
  logic sclk_q, strb_q, lclk_q, sr, st;
  logic [5:0] nrise;
  logic [3:0] quiet, scnt;
  logic [4:0] lp;
  assign sr = clk_en && sclk && !sclk_q;
  assign st = clk_en && frame_strobe && !strb_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      strb_q <= 1'b0;
      nrise <= 6'h0;
      quiet <= 4'h0;
      scnt <= 4'hf;
    end else begin
      sclk_q <= sclk;
      strb_q <= frame_strobe;
      nrise <= st ? 6'h0 : (sr && nrise != 6'h21) ? nrise + 6'h1 : nrise;
      quiet <= (sr || st || nrise != 6'h0) ? 4'h0 : (quiet == 4'hf) ? quiet : quiet + 4'h1;
      scnt <= st ? 4'h0 : (scnt == 4'hf) ? scnt : scnt + 4'h1;
    end
  end
  // pulses of the current link packet
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lclk_q <= 1'b0;
      lp <= 5'h0;
    end else begin
      lclk_q <= link_clk;
      lp <= !link_frame ? 5'h0 : (link_clk && !lclk_q) ? lp + 5'h1 : lp;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  idle_lock_a: assert property (quiet >= 4'h4 |->
    shared_lock_serial_out == $past(lock_indication))
    else $error("shared pin does not follow lock when idle");
  tail_quiet_a: assert property (nrise >= 6'h1a |-> !shared_lock_serial_out)
    else $error("shared pin not low after the read bits");
  rise_move_a: assert property ($past(nrise) != 6'h0 && nrise != 6'h0 &&
    $changed(shared_lock_serial_out) |-> $past(sr, 2) || $past(sr, 3))
    else $error("read bit moved away from a serial clock rise");
  busy_pair_a: assert property (link_busy == link_frame)
    else $error("busy and link frame differ");
  link_idle_a: assert property (!link_frame |-> !link_clk)
    else $error("link clock runs outside a packet");
  data_hold_a: assert property (link_clk && $past(link_clk) |-> $stable(link_data))
    else $error("link data moved while link clock high");
  start_cause_a: assert property ($rose(link_frame) |-> scnt inside {[1:5]})
    else $error("link packet without a recent frame strobe");
  pulse_count_a: assert property ($fell(link_frame) |-> lp == 5'h10)
    else $error("link packet did not carry sixteen pulses");
  mode_sticky_a: assert property (open_mode_active |=> open_mode_active)
    else $error("protocol choice dropped without reset");
endmodule
bind omsp_serial_port omsp_serial_port_props i_omsp_serial_port_props (.clock, .sys_rst,
  .clk_en, .sclk, .sdi, .frame_strobe, .shared_lock_serial_out, .lock_indication, .link_clk,
  .link_data, .link_frame, .open_mode_active, .legacy_single_slave_protocol, .link_busy);

//--- tb/omsp_host.sv
// host model: shifts 32-bit frames msb first, then strobes, collecting read-back bits
// assumes the caller enters xfer just after a rising clock edge
`timescale 1ns/100ps
module omsp_host (
  // system
  input wire logic clock,
  // serial pins
  output logic sclk,
  output logic sdi,
  output logic frame_strobe,
  input wire logic shared_lock_serial_out
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    frame_strobe = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, output logic [23:0] rd);
    for (int i = 31; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= w[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      // read bit sampled while sclk is still high, ahead of its fall
      @(negedge clock);
      if (i > 7) begin
        rd[i - 8] = shared_lock_serial_out;
      end
      @(posedge clock);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge clock);
    frame_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    frame_strobe <= 1'b0;
    // no pull on sdi, so it shows the inverse of the last bit between frames
    sdi <= ~sdi;
    repeat (4) @(posedge clock);
  endtask
endmodule

//--- tb/open_mode_serial_port_tb_top.sv
// testbench of the open mode serial port: registers, chip address, link and soft reset
// assumes the host model paces sclk slowly against the 10 MHz system clock
`timescale 1ns/100ps
module open_mode_serial_port_tb_top;
  logic clock, sys_rst, lock_indication, sclk, sdi, frame_strobe, shared_lock_serial_out;
  logic link_clk, link_data, link_frame, open_mode_active, legacy_single_slave_protocol;
  logic link_busy;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int lhi = 0;
  int lhi_max = 0;
  logic lclk_q = 1'b0;
  logic [15:0] lsr = 16'h0;
  logic [23:0] rd;
  omsp_serial_port i_omsp_serial_port (.clock, .sys_rst, .clk_en(1'b1), .sclk, .sdi,
    .frame_strobe, .shared_lock_serial_out, .lock_indication, .link_clk, .link_data,
    .link_frame, .open_mode_active, .legacy_single_slave_protocol, .link_busy);
  omsp_host i_omsp_host (.clock, .sclk, .sdi, .frame_strobe, .shared_lock_serial_out);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // link capture on rising link clock, plus longest high phase seen
  always @(posedge clock) begin
    cyc <= cyc + 1;
    lclk_q <= link_clk;
    if (link_clk && !lclk_q) begin
      lsr <= {lsr[14:0], link_data};
    end
    lhi <= link_clk ? lhi + 1 : 0;
    if (lhi > lhi_max) begin
      lhi_max <= lhi;
    end
    if (cyc % 7 == 0) begin
      lock_indication <= ~lock_indication;
    end
    if (cyc == 25000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    i_omsp_host.xfer({d, a, 3'h0}, rd);
  endtask
  task automatic rdreg(input logic [4:0] a, input logic [23:0] exp);
    wr(5'h00, {19'h0, a});
    wr(5'h00, {19'h0, a});
    chk(rd, exp);
  endtask
  task automatic t_regs;
    rdreg(5'h0a, 24'h002000);
    chk({22'h0, legacy_single_slave_protocol, open_mode_active}, 24'h1);
    rdreg(5'h00, omsp_pkg::CHIP_ID);
    wr(5'h03, 24'ha5c3e1);
    rdreg(5'h03, 24'ha5c3e1);
    $display("test regs done");
  endtask
  task automatic t_foreign;
    for (int c = 1; c < 8; c++) begin
      i_omsp_host.xfer({24'h3c3c3c, 5'h03, 3'(c)}, rd);
    end
    // a foreign read address write must leave the stored one (03h) in place
    i_omsp_host.xfer({24'h00000a, 5'h00, 3'h5}, rd);
    i_omsp_host.xfer({24'h00000a, 5'h00, 3'h5}, rd);
    chk(rd, 24'ha5c3e1);
    rdreg(5'h03, 24'ha5c3e1);
    $display("test foreign chip done");
  endtask
  task automatic t_link;
    lhi_max = 0;
    wr(5'h05, 24'h00b5a2);
    repeat (80) @(posedge clock);
    chk({8'h0, lsr}, 24'h00b5a2);
    chk(24'(lhi_max), 24'h2);
    wr(5'h0a, 24'h004000);
    lhi_max = 0;
    wr(5'h05, 24'h004c3b);
    repeat (150) @(posedge clock);
    chk({8'h0, lsr}, 24'h004c3b);
    chk(24'(lhi_max), 24'h4);
    rdreg(5'h05, 24'h004c3b);
    $display("test link done");
  endtask
  task automatic t_config;
    wr(5'h02, 24'h000004);
    wr(5'h06, 24'h0c1234);
    wr(5'h09, 24'h123456);
    wr(5'h05, 24'h000110);
    wr(5'h03, 24'h000030);
    wr(5'h04, 24'h800000);
    rdreg(5'h02, 24'h000004);
    chk({8'h0, lsr}, 24'h000110);
    wr(5'h03, 24'h000031);
    wr(5'h04, 24'h400000);
    rdreg(5'h04, 24'h400000);
    rdreg(5'h03, 24'h000031);
    $display("test config order done");
  endtask
  task automatic t_soft;
    wr(5'h00, 24'h000003);
    wr(5'h00, 24'h000023);
    wr(5'h01, 24'h000000);
    chk(rd, omsp_pkg::CHIP_ID);
    $display("test soft reset done");
  endtask
  task automatic test_done;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    lock_indication = 1'b0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_regs();
    t_foreign();
    t_link();
    t_soft();
    t_config();
    test_done();
  end
endmodule
